// ===== logic/hw_watchdog.sv
`timescale 1ns/100ps

module hw_watchdog
  import wdt_pkg::*;
#(
  parameter int CNT_W   = CNT_WIDTH,
  parameter int PRE_W   = PRE_WIDTH,
  parameter int PULSE_N = PULSE_PERIODS
)
(
  input  wire logic       I_REF_CLK,
  input  wire logic       I_SYS_RST,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_osc_run,
  input  wire logic       i_wake_int_n,
  output logic [7:0]      o_sfr_rdata,
  output logic            o_sfr_hit,
  output logic            o_rst_pin,
  output logic            o_wdt_enabled
);

  // ----------------------------------------------------------------
  // enables for machine and peripheral rates
  // ----------------------------------------------------------------
  localparam int MW = $clog2(MACHINE_CYCLES + 1);
  localparam int PW = $clog2(PERIPH_CYCLES + 1);
  localparam int NW = $clog2(PULSE_N + 1);
  localparam logic [MW-1:0] M_LAST = MW'(MACHINE_CYCLES - 1);
  localparam logic [PW-1:0] P_LAST = PW'(PERIPH_CYCLES - 1);
  localparam logic [NW-1:0] N_LAST = NW'(PULSE_N - 1);

  sfr_req_t    req;
  wdt_state_t  state, next_state;
  logic [MW-1:0] mdiv, next_mdiv;
  logic [PW-1:0] pdiv, next_pdiv;
  logic        m_tick, p_tick;
  // wake pin is asynchronous: three stages, change counted when last two agree
  logic [2:0]  wake_sync;
  logic        wake_hi, next_wake_hi;

  assign req = '{wr: i_sfr_wr, rd: i_sfr_rd, addr: i_sfr_addr, wdata: i_sfr_wdata};

  always_comb
  begin
    m_tick    = (mdiv == M_LAST);
    p_tick    = (pdiv == P_LAST);
    next_mdiv = m_tick ? '0 : mdiv + MW'(1);
    // restarting the divider with the pulse makes it span whole peripheral periods
    next_pdiv = (p_tick || ((state != ST_FIRE) && (next_state == ST_FIRE)))
              ? '0 : pdiv + PW'(1);
    next_wake_hi = (wake_sync[2] == wake_sync[1]) ? wake_sync[1] : wake_hi;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      mdiv      <= '0;
      pdiv      <= '0;
      wake_sync <= 3'h7;
      wake_hi   <= 1'b1;
    end
    else
    begin
      mdiv      <= next_mdiv;
      pdiv      <= next_pdiv;
      wake_sync <= {wake_sync[1:0], i_wake_int_n};
      wake_hi   <= next_wake_hi;
    end
  end

  // ----------------------------------------------------------------
  // registers, key sequence and counter
  // ----------------------------------------------------------------
  logic           armed_run, next_armed_run;
  logic [2:0]     sel, next_sel;
  logic [PRE_W-1:0] pre, next_pre;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [NW-1:0]  plen, next_plen;
  logic           key_ok, pre_tick, run_ok, wr_restart;

  always_comb
  begin
    wr_restart = req.wr && (req.addr == ADDR_RESTART);
    key_ok     = wr_restart && (req.wdata == KEY_SECOND) && ((state == ST_ARMED) || armed_run);
    run_ok     = i_osc_run && wake_hi;
    // select code n divides the machine tick by 2**n before the counter
    pre_tick   = (sel == SEL_RESET) ? 1'b1
               : (pre[PRE_W-1:0] == PRE_W'((1 << sel) - 1));
    next_state = state;
    next_sel   = sel;
    next_pre   = pre;
    next_cnt   = cnt;
    next_plen  = plen;
    if (req.wr && (req.addr == ADDR_TIMEOUT))
      next_sel = req.wdata[SEL_MSB:SEL_LSB];
    case (state)
      ST_OFF, ST_ARMED:
      begin
        if (wr_restart)
          next_state = (req.wdata == KEY_FIRST) ? ST_ARMED : ST_OFF;
        if (key_ok)
        begin
          next_state = ST_RUN;
          next_cnt   = '0;
          next_pre   = '0;
        end
      end
      ST_RUN:
      begin
        // the enable stays set; a bad write only drops the pending key
        // reaching the top is already the overflow, so a late key cannot save it
        if (cnt == CNT_TOP[CNT_W-1:0])
        begin
          next_state = ST_FIRE;
          next_plen  = '0;
        end
        else if (key_ok)
        begin
          next_cnt = '0;
          next_pre = '0;
        end
        else if (m_tick && run_ok)
        begin
          next_pre = pre_tick ? '0 : pre + PRE_W'(1);
          if (pre_tick)
            next_cnt = cnt + CNT_W'(1);
        end
      end
      ST_FIRE:
      begin
        if (p_tick)
        begin
          if (plen == N_LAST)
          begin
            next_state = ST_OFF;
            next_cnt   = '0;
            next_pre   = '0;
            next_sel   = SEL_RESET;
          end
          else
            next_plen = plen + NW'(1);
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  // the run state is kept distinct from armed so a bad key cannot clear it
  always_comb
  begin
    next_armed_run = armed_run;
    if (state == ST_RUN && wr_restart)
      next_armed_run = (req.wdata == KEY_FIRST);
    if (state != ST_RUN)
      next_armed_run = 1'b0;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state     <= ST_OFF;
      sel       <= SEL_RESET;
      pre       <= '0;
      cnt       <= '0;
      plen      <= '0;
      armed_run <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      sel       <= next_sel;
      pre       <= next_pre;
      cnt       <= next_cnt;
      plen      <= next_plen;
      armed_run <= next_armed_run;
    end
  end

  // ----------------------------------------------------------------
  // read side: only the select field is visible
  // ----------------------------------------------------------------
  logic [7:0] rdata, next_rdata;
  always_comb
  begin
    next_rdata = rdata;
    if (req.rd)
      next_rdata = (req.addr == ADDR_TIMEOUT) ? {5'h00, sel} : 8'h00;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      rdata <= 8'h00;
    else
      rdata <= next_rdata;
  end

  assign o_sfr_rdata   = rdata;
  assign o_sfr_hit     = req.rd && (req.addr == ADDR_TIMEOUT);
  assign o_rst_pin     = (state == ST_FIRE);
  assign o_wdt_enabled = (state == ST_RUN) || (state == ST_FIRE);

  // ----------------------------------------------------------------
  // reset pulse length monitor
  // ----------------------------------------------------------------
  localparam int            PULSE_CLKS = PULSE_N * PERIPH_CYCLES;
  localparam int            FW         = $clog2(PULSE_CLKS + 2);
  localparam logic [FW-1:0] PULSE_LEN  = FW'(PULSE_CLKS);

  // counts clocks while the pin is high so the whole pulse can be measured
  logic [FW-1:0] fire_len, next_fire_len;

  always_comb
  begin
    next_fire_len = o_rst_pin ? fire_len + FW'(1) : '0;
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      fire_len <= '0;
    else
      fire_len <= next_fire_len;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_fire_at_top: assert property (
    (state == ST_RUN) && (cnt == CNT_TOP[CNT_W-1:0]) |=> o_rst_pin)
    else $error("overflow did not raise reset pin");
  a_key_restarts: assert property (
    (state == ST_RUN) && key_ok && (cnt != CNT_TOP[CNT_W-1:0])
      |=> (cnt == '0) && (state == ST_RUN))
    else $error("key sequence did not clear count");
  a_key_enables: assert property (
    (state == ST_ARMED) && key_ok |=> o_wdt_enabled)
    else $error("key sequence did not enable");
  a_stay_enabled: assert property (
    (state == ST_RUN) |=> o_wdt_enabled)
    else $error("watchdog left enabled state");
  a_no_skip_key: assert property (
    (state == ST_OFF) && req.wr && (req.addr == ADDR_RESTART)
      && (req.wdata == KEY_SECOND) |=> !o_wdt_enabled)
    else $error("lone second key enabled watchdog");
  a_count_step: assert property (
    (state == ST_RUN) && m_tick && run_ok && pre_tick && !key_ok
      && (cnt != CNT_TOP[CNT_W-1:0]) |=> cnt == $past(cnt) + CNT_W'(1))
    else $error("counter did not advance");
  a_wake_hold: assert property (
    (state == ST_RUN) && !wake_hi && !key_ok |=> $stable(cnt))
    else $error("counter moved while wake pin low");
  a_pulse_start: assert property (
    $rose(o_rst_pin) |-> (plen == '0))
    else $error("reset pulse length not restarted");
  a_sel_write: assert property (
    req.wr && (req.addr == ADDR_TIMEOUT) && (state != ST_FIRE)
      |=> sel == $past(req.wdata[SEL_MSB:SEL_LSB]))
    else $error("select field not stored");
  a_off_from_reset: assert property (
    $past(I_SYS_RST) |-> !o_wdt_enabled && !o_rst_pin)
    else $error("watchdog not disabled after reset");
  a_pulse_width: assert property (
    $fell(o_rst_pin) |-> (fire_len == PULSE_LEN))
    else $error("reset pulse length wrong");
  a_pulse_ends_off: assert property (
    $fell(o_rst_pin) |-> !o_wdt_enabled && (sel == SEL_RESET))
    else $error("watchdog still enabled after its own reset");
  a_osc_hold: assert property (
    (state == ST_RUN) && !i_osc_run && !key_ok |=> $stable(cnt))
    else $error("counter moved while oscillator stopped");
  a_read_hides: assert property (
    req.rd && (req.addr != ADDR_TIMEOUT) |=> (o_sfr_rdata == 8'h00))
    else $error("restart or count visible on read");

  c_enable:  cover property ((state == ST_ARMED) ##1 (state == ST_RUN));
  c_service: cover property ((state == ST_RUN) && key_ok);
  c_fire:    cover property ($rose(o_rst_pin));
  c_release: cover property ($fell(o_rst_pin));
  c_hold:    cover property ((state == ST_RUN) && !run_ok);

endmodule

// ===== common/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // special function register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESTART  = 8'ha6;
  localparam logic [7:0] ADDR_TIMEOUT  = 8'ha7;
  localparam logic [7:0] KEY_FIRST     = 8'h1e;
  localparam logic [7:0] KEY_SECOND    = 8'he1;
  localparam logic [2:0] SEL_RESET     = 3'h0;
  localparam int         SEL_LSB       = 0;
  localparam int         SEL_MSB       = 2;

  // ----------------------------------------------------------------
  // counter geometry and timing
  // ----------------------------------------------------------------
  localparam int          CNT_WIDTH    = 14;
  localparam logic [13:0] CNT_TOP      = 14'h3fff;
  localparam int          PRE_WIDTH    = 7;
  localparam int          PULSE_PERIODS = 96;
  localparam int          CLK_MHZ      = 100;
  localparam int          MACHINE_NS   = 1000;
  localparam int          MACHINE_CYCLES = (MACHINE_NS * CLK_MHZ + 999) / 1000;
  localparam int          PERIPH_NS    = 500;
  localparam int          PERIPH_CYCLES = (PERIPH_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b11,
    ST_FIRE  = 2'b10
  } wdt_state_t;

endpackage

// ===== tb/tb.sv
`timescale 1ns/100ps

module tb
  import wdt_pkg::*;
;
  localparam int CNT_SIM   = 4;
  localparam int PULSE_SIM = 4;
  localparam int TOP_TICKS = (1 << CNT_SIM) - 1;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       exp_en;
  } row_t;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       osc_run = 1'b1;
  logic       wake_n = 1'b1;
  logic [7:0] rdata;
  logic       hit;
  logic       rst_pin;
  logic       enabled;
  int         fails = 0;
  int         samples_checked = 0;
  row_t       rows [9];
  logic [7:0] rv;

  always #5 clk = ~clk;

  // shortened counter and pulse keep every overflow within a few thousand cycles
  hw_watchdog #(.CNT_W(CNT_SIM), .PRE_W(PRE_WIDTH), .PULSE_N(PULSE_SIM)) hw_watchdog_inst (
    .I_REF_CLK    (clk),
    .I_SYS_RST    (rst),
    .i_sfr_wr     (wr),
    .i_sfr_rd     (rd),
    .i_sfr_addr   (addr),
    .i_sfr_wdata  (wdata),
    .i_osc_run    (osc_run),
    .i_wake_int_n (wake_n),
    .o_sfr_rdata  (rdata),
    .o_sfr_hit    (hit),
    .o_rst_pin    (rst_pin),
    .o_wdt_enabled(enabled)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic rng(input string name, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
      fails++;
    end
  endtask

  task automatic hw_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    #1;
    chk("hit", {15'h0, (a == ADDR_TIMEOUT)}, {15'h0, hit});
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic arm();
    sfr_wr(ADDR_RESTART, KEY_FIRST);
    sfr_wr(ADDR_RESTART, KEY_SECOND);
  endtask

  // counts from now to the reset pulse, then its width
  task automatic overflow(input int sel);
    int n;
    int w;
    int lo;
    n = 0;
    w = 0;
    // machine tick phase and wake sync lag give at most one tick plus a few clocks
    lo = ((TOP_TICKS << sel) - 1) * MACHINE_CYCLES;
    while (rst_pin !== 1'b1 && n < 8000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    rng("ovf_time", lo, lo + MACHINE_CYCLES + 6, n);
    while (rst_pin === 1'b1 && w < 2000)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    rng("pulse_len", PULSE_SIM * PERIPH_CYCLES, PULSE_SIM * PERIPH_CYCLES, w);
    repeat (2) @(posedge clk);
    #1;
    chk("en_after_ovf", 16'h0, {15'h0, enabled});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    $display("BAD watchdog expected done seen hang");
    fails++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rows = '{'{ADDR_RESTART, KEY_SECOND, 1'b0}, '{ADDR_RESTART, KEY_FIRST, 1'b0},
             '{ADDR_RESTART, 8'h55, 1'b0}, '{ADDR_RESTART, KEY_SECOND, 1'b0},
             '{ADDR_RESTART, KEY_FIRST, 1'b0}, '{ADDR_TIMEOUT, 8'h05, 1'b0},
             '{ADDR_RESTART, KEY_SECOND, 1'b1}, '{ADDR_RESTART, 8'h00, 1'b1},
             '{ADDR_RESTART, KEY_SECOND, 1'b1}};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk("en_reset", 16'h0, {15'h0, enabled});
    sfr_rd(ADDR_TIMEOUT, rv);
    chk("sel_reset", {13'h0, SEL_RESET}, {13'h0, rv[2:0]});
    sfr_rd(ADDR_RESTART, rv);
    chk("restart_read", 16'h0, {8'h0, rv});
    foreach (rows[i])
    begin
      sfr_wr(rows[i].addr, rows[i].data);
      @(posedge clk);
      #1;
      chk("en_row", {15'h0, rows[i].exp_en}, {15'h0, enabled});
    end
    sfr_rd(ADDR_TIMEOUT, rv);
    chk("sel_rw", 16'h5, {13'h0, rv[2:0]});
    $display("test key_sequence done");
    hw_reset();
    #1;
    chk("en_hw_reset", 16'h0, {15'h0, enabled});
    sfr_rd(ADDR_TIMEOUT, rv);
    chk("sel_hw_reset", 16'h0, {13'h0, rv[2:0]});
    $display("test hw_reset done");
    for (int s = 0; s < 3; s++)
    begin
      sfr_wr(ADDR_TIMEOUT, 8'(s));
      arm();
      overflow(s);
      sfr_rd(ADDR_TIMEOUT, rv);
      chk("sel_after_ovf", 16'h0, {13'h0, rv[2:0]});
    end
    $display("test prescale done");
    arm();
    repeat (5 * MACHINE_CYCLES) @(posedge clk);
    arm();
    overflow(0);
    $display("test service done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      if (k == 0)
        osc_run <= 1'b0;
      else
        wake_n <= 1'b0;
      // let the wake pin pass its synchroniser before the watchdog starts
      repeat (8) @(posedge clk);
      arm();
      // longer than a full timeout, so a counter that runs on would fire here
      repeat (TOP_TICKS * MACHINE_CYCLES + 100) @(posedge clk);
      #1;
      chk("frozen", 16'h1, {14'h0, rst_pin, enabled});
      @(posedge clk);
      osc_run <= 1'b1;
      wake_n  <= 1'b1;
      overflow(0);
    end
    $display("test freeze done");
    final_report();
  end
endmodule
